//--- logic/srr_bank.sv
// sequencer result register bank: fifteen read-side result slots
// assumes a decoded register read strobe from the serial front end on mclk,
// and a sequencer buffer presented in parallel; parity is added outside
//
// Behaviour
// - fifteen result slots at consecutive addresses E1..EF in slot order
// - resistance slot reports ratio times 2048 when new, zero otherwise
// - ratio is unsigned, four integer bits over eleven fraction bits
// - voltage slot: bit 14 new flag cleared on read, 13:12 zero, 11:0 code
// - reading the copy command register copies the buffer into all slots
// - with sync copy enable set, a sync toggle also copies; enable resets to one
`timescale 1ns/1ps
`include "srr_defs.svh"
module srr_bank #(
  parameter int SLOTS = `SRR_SLOT_COUNT
) (
  input  wire logic                      mclk,
  input  wire logic                      nrst,
  input  wire logic                      swReset,
  input  wire logic                      rdStrobe,
  input  wire srr_pkg::srr_addr_t        rdAddr,
  input  wire logic                      syncPin,
  input  wire logic                      syncCopyEnWr,
  input  wire logic                      syncCopyEnVal,
  input  wire logic [SLOTS-1:0]          slotModeRes,
  input  wire logic [SLOTS-1:0]          bufNew,
  input  wire srr_pkg::srr_word_t [SLOTS-1:0] bufData,
  output srr_pkg::srr_word_t             rdData,
  output logic                           rdValid,
  output logic                           syncCopyEn,
  output logic                           copyDone
);
  import srr_pkg::*;

  // ***************************
  // address decode
  // ***************************
  function automatic logic isSlotAddr(input srr_addr_t a);
    return (a >= `SRR_ADDR_FIRST) && (a <= `SRR_ADDR_LAST);
  endfunction

  function automatic logic [3:0] slotIndex(input srr_addr_t a);
    return 4'(a - `SRR_ADDR_FIRST);
  endfunction

  function automatic logic isCopyAddr(input srr_addr_t a);
    return a == `SRR_ADDR_COPY_CMD;
  endfunction

  // ***************************
  // request decode
  // ***************************
  logic       slotReq;
  logic       copyReq;
  logic [3:0] slotIdx;
  assign slotReq = rdStrobe && isSlotAddr(rdAddr);
  assign copyReq = rdStrobe && isCopyAddr(rdAddr);
  assign slotIdx = slotIndex(rdAddr);

  // ***************************
  // sync input: three flops, a change counts when stages two and three agree
  // ***************************
  // level starts low: a pin held high through reset gives one copy after release
  logic [2:0] syncSh_q;
  logic       syncLvl_q;
  logic       syncStable;
  logic       syncToggle;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncSh_q <= 3'h0;
    end else begin
      syncSh_q <= {syncSh_q[1:0], syncPin};
    end
  end

  assign syncStable = (syncSh_q[1] == syncSh_q[2]);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncLvl_q <= 1'b0;
    end else if (syncStable) begin
      syncLvl_q <= syncSh_q[2];
    end
  end

  // either edge of the pin counts as a toggle
  assign syncToggle = syncStable && (syncSh_q[2] != syncLvl_q);

  // ***************************
  // sync copy enable
  // ***************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncCopyEn <= `SRR_SYNC_COPY_RST;
    end else if (swReset) begin
      syncCopyEn <= `SRR_SYNC_COPY_RST;
    end else if (syncCopyEnWr) begin
      syncCopyEn <= syncCopyEnVal;
    end
  end

  // ***************************
  // copy trigger
  // ***************************
  logic pinCopy;
  logic copyPulse;
  assign pinCopy   = syncCopyEn && syncToggle;
  assign copyPulse = copyReq || pinCopy;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      copyDone <= 1'b0;
    end else begin
      copyDone <= copyPulse && !swReset;
    end
  end

  // ***************************
  // slots
  // ***************************
  srr_mode_t        slotMode [SLOTS];
  srr_word_t        slotWord [SLOTS];
  logic [SLOTS-1:0] slotRead;

  // one-hot select; the copy register address never hits a slot, so no overlap
  always_comb begin
    slotRead = '0;
    for (int i = 0; i < SLOTS; i++) begin
      slotRead[i] = slotReq && (slotIdx == 4'(i));
    end
  end

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gSlot
      assign slotMode[g] = slotModeRes[g] ? SRR_MODE_RES : SRR_MODE_VOLT;
      srr_slot uSlot (
        .mclk      (mclk),
        .nrst      (nrst),
        .swReset   (swReset),
        .copyPulse (copyPulse),
        .mode      (slotMode[g]),
        .bufNew    (bufNew[g]),
        .bufData   (bufData[g]),
        .readPulse (slotRead[g]),
        .slotWord  (slotWord[g])
      );
    end
  endgenerate

  // ***************************
  // read data: value before the read side effect
  // ***************************
  srr_word_t rdWord;

  // unmapped and copy-register reads fall through to zero
  always_comb begin
    rdWord = `SRR_WORD_RESET;
    for (int i = 0; i < SLOTS; i++) begin
      if (slotRead[i]) begin
        rdWord = slotWord[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData <= `SRR_WORD_RESET;
    end else if (rdStrobe) begin
      rdData <= rdWord;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdStrobe;
    end
  end
endmodule // srr_bank

//--- logic/srr_defs.svh
// constants for the sequencer result register bank
// assumes inclusion by bare name from logic/ sources
`ifndef SRR_DEFS_SVH
`define SRR_DEFS_SVH
`define SRR_ADDR_FIRST     8'hE1
`define SRR_ADDR_LAST      8'hEF
`define SRR_ADDR_COPY_CMD  8'hDF
`define SRR_SLOT_COUNT     15
`define SRR_FLAG_BIT       14
`define SRR_VCODE_MSB      11
`define SRR_RATIO_MSB      14
`define SRR_RATIO_INT_LSB  11
`define SRR_RATIO_SCALE    2048
`define SRR_WORD_RESET     15'h0000
`define SRR_SYNC_COPY_RST  1'b1
`endif

//--- logic/srr_pkg.sv
// types for the sequencer result register bank
// assumes srr_defs.svh is on the include path
package srr_pkg;
  typedef logic [7:0]  srr_addr_t;
  typedef logic [14:0] srr_word_t;
  typedef enum logic {SRR_MODE_VOLT, SRR_MODE_RES} srr_mode_t;
endpackage

//--- logic/srr_slot.sv
// one result slot: holds a 15-bit word, handles copy and read side effects
// assumes copy and read strobes are one-cycle pulses on mclk
`timescale 1ns/1ps
`include "srr_defs.svh"
module srr_slot (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              swReset,
  input  wire logic              copyPulse,
  input  wire srr_pkg::srr_mode_t mode,
  input  wire logic              bufNew,
  input  wire srr_pkg::srr_word_t bufData,
  input  wire logic              readPulse,
  output srr_pkg::srr_word_t     slotWord
);
  import srr_pkg::*;
  srr_word_t slot_q;
  srr_word_t slot_d;
  // ***************************
  // next value
  // ***************************
  always_comb begin
    slot_d = slot_q;
    if (readPulse) begin
      if (mode == SRR_MODE_RES) begin
        slot_d = `SRR_WORD_RESET;
      end else begin
        slot_d[`SRR_FLAG_BIT] = 1'b0;
      end
    end
    // copy wins over read-clear so a fresh value is never lost
    if (copyPulse) begin
      if (mode == SRR_MODE_RES) begin
        slot_d = bufNew ? bufData : `SRR_WORD_RESET;
      end else begin
        slot_d = {bufNew, 2'b00, bufData[`SRR_VCODE_MSB:0]};
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_q <= `SRR_WORD_RESET;
    end else if (swReset) begin
      slot_q <= `SRR_WORD_RESET;
    end else begin
      slot_q <= slot_d;
    end
  end
  assign slotWord = slot_q;
endmodule // srr_slot

//--- sim/srr_bank_assertions.sv
// port checker for the result register bank
// assumes binding onto srr_bank, reads answered one cycle later
`timescale 1ns/1ps
module srr_bank_chk #(
  parameter int SLOTS = 15
) (
  input wire logic               mclk,
  input wire logic               nrst,
  input wire logic               swReset,
  input wire logic               rdStrobe,
  input wire srr_pkg::srr_addr_t rdAddr,
  input wire logic [SLOTS-1:0]   slotModeRes,
  input wire srr_pkg::srr_word_t rdData,
  input wire logic               rdValid,
  input wire logic               syncCopyEn,
  input wire logic               copyDone
);
  import srr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire slotHit = rdAddr >= 8'hE1 && rdAddr <= 8'hEF;
  wire isRes = slotModeRes[rdAddr[3:0] - 4'h1];
  sequence slotRd; rdStrobe && slotHit; endsequence
  // second read of one slot, no copy between
  sequence reRd;
    slotRd ##1 !copyDone ##1 (rdStrobe && !copyDone && rdAddr == $past(rdAddr, 2));
  endsequence
  a_read_answer: assert property (rdValid == $past(rdStrobe))
    else $error("read answer not one cycle later");
  a_unmapped_zero: assert property (rdStrobe && !slotHit |=> rdData == 15'h0000)
    else $error("non-slot read not zero");
  a_copy_done: assert property (rdStrobe && rdAddr == 8'hDF && !swReset |=> copyDone)
    else $error("copy command gave no copy");
  a_sw_clear: assert property (swReset ##2 (slotRd && !copyDone) |=> rdData == 15'h0000)
    else $error("slot not cleared by soft reset");
  a_res_reread: assert property (reRd ##0 isRes |=> rdData == 15'h0000)
    else $error("ratio not cleared by read");
  a_flag_reread: assert property (reRd ##0 !isRes |=> !rdData[14])
    else $error("new flag not cleared by read");
  a_volt_resv: assert property (slotRd ##0 !isRes |=> rdData[13:12] == 2'b00)
    else $error("reserved bits set");
  a_en_restore: assert property (swReset |=> syncCopyEn)
    else $error("sync copy enable not restored");
endmodule // srr_bank_chk
bind srr_bank srr_bank_chk #(.SLOTS(SLOTS)) u_chk (.mclk, .nrst, .swReset, .rdStrobe,
  .rdAddr, .slotModeRes, .rdData, .rdValid, .syncCopyEn, .copyDone);

//--- sim/srr_host_model.sv
// host side model: single register reads over the read port
// assumes answer exactly one cycle after the taking edge
`timescale 1ns/1ps
module srr_host_model (
  input  wire logic               mclk,
  output srr_pkg::srr_addr_t      rdAddr,
  output logic                    rdStrobe,
  input  wire srr_pkg::srr_word_t rdData,
  input  wire logic               rdValid
);
  import srr_pkg::*;
  initial begin
    rdStrobe = 1'b0;
    rdAddr = 8'h00;
  end
  // a missing answer shows as all ones
  task automatic rd(input srr_addr_t a, output srr_word_t d);
    @(posedge mclk);
    rdStrobe <= 1'b1;
    rdAddr <= a;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 d = rdValid ? rdData : 15'h7FFF;
  endtask
endmodule // srr_host_model

//--- sim/testbench.sv
// self-checking bench for the result register bank
// assumes the host model owns the read port
`timescale 1ns/1ps
module testbench;
  import srr_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, swReset = 1'b0, syncPin = 1'b0;
  logic syncCopyEnWr = 1'b0, syncCopyEnVal = 1'b0;
  logic rdStrobe, rdValid, syncCopyEn, copyDone;
  logic [14:0] slotModeRes = 15'h5555, bufNew = 15'h7FFF;
  srr_word_t [14:0] bufData;
  srr_addr_t rdAddr;
  srr_word_t rdData, d;
  int errorCnt = 0, nChecks = 0;
  srr_bank u_srr_bank (.mclk, .nrst, .swReset, .rdStrobe, .rdAddr, .syncPin,
    .syncCopyEnWr, .syncCopyEnVal, .slotModeRes, .bufNew, .bufData,
    .rdData, .rdValid, .syncCopyEn, .copyDone);
  srr_host_model u_srr_host_model (.mclk, .rdAddr, .rdStrobe, .rdData, .rdValid);
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic ck(input srr_word_t got, input srr_word_t exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_copy(input logic [14:0] nw);
    srr_word_t w;
    @(posedge mclk) bufNew <= nw;
    u_srr_host_model.rd(8'hDF, d);
    for (int g = 0; g < 15; g++) begin
      w = bufData[g];
      u_srr_host_model.rd(8'hE1 + 8'(g), d);
      if (slotModeRes[g]) ck(d, nw[g] ? w : 15'h0000);
      else ck(d, {nw[g], 2'b00, w[11:0]});
      u_srr_host_model.rd(8'hE1 + 8'(g), d);
      ck(d, slotModeRes[g] ? 15'h0000 : {3'b000, w[11:0]});
    end
    $display("copy test done");
  endtask
  task automatic cnt_copy(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk);
      if (copyDone === 1'b1) c++;
    end
  endtask
  task automatic t_reset_val;
    for (int g = 0; g < 15; g++) begin
      u_srr_host_model.rd(8'hE1 + 8'(g), d);
      ck(d, 15'h0000);
    end
    $display("reset value test done");
  endtask
  task automatic t_sync;
    int c;
    @(posedge mclk);
    bufNew  <= 15'h7FFF;
    syncPin <= 1'b1;
    cnt_copy(8, c);
    ck(15'(c), 15'h0001);
    u_srr_host_model.rd(8'hE2, d);
    ck(d, {1'b1, 2'b00, bufData[1][11:0]});
    @(posedge mclk);
    syncCopyEnWr  <= 1'b1;
    syncCopyEnVal <= 1'b0;
    @(posedge mclk);
    syncCopyEnWr  <= 1'b0;
    syncPin       <= 1'b0;
    cnt_copy(8, c);
    ck(15'(c), 15'h0000);
    ck({14'h0, syncCopyEn}, 15'h0000);
    $display("sync test done");
  endtask
  task automatic t_unmapped;
    u_srr_host_model.rd(8'hE0, d);
    ck(d, 15'h0000);
    u_srr_host_model.rd(8'hF0, d);
    ck(d, 15'h0000);
    $display("unmapped test done");
  endtask
  task automatic t_sw;
    @(posedge mclk) swReset <= 1'b1;
    @(posedge mclk) swReset <= 1'b0;
    u_srr_host_model.rd(8'hE2, d);
    ck(d, 15'h0000);
    ck({14'h0, syncCopyEn}, 15'h0001);
    $display("soft reset test done");
  endtask
  initial begin
    @(posedge mclk);
    for (int g = 0; g < 15; g++) bufData[g] <= 15'h7A50 + 15'(g);
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_val;
    t_copy(15'h7FFF);
    t_copy(15'h2AD3);
    t_sync;
    t_sw;
    t_unmapped;
    summarize;
  end
  initial begin
    #50000;
    errorCnt++;
    summarize;
  end
endmodule // testbench
